// ==== mbe_map.svh ====
// Register offsets, command bytes and timing counts for the multiplexed EEPROM host controller.
`ifndef MBE_MAP_SVH
`define MBE_MAP_SVH
`define MBE_REG_CTRL      4'h0
`define MBE_REG_ADDR      4'h4
`define MBE_REG_WDATA     4'h8
`define MBE_REG_STATUS    4'hc
`define MBE_CTRL_GO       0
`define MBE_CTRL_READ     1
`define MBE_CTRL_UNLOCK   2
`define MBE_CTRL_POLL     3
`define MBE_CTRL_INHIBIT  4
`define MBE_CTRL_LOCKSEQ  5
`define MBE_STAT_BUSY     0
`define MBE_STAT_TOGGLE   1
`define MBE_STAT_PGFULL   2
`define MBE_PAGE_MAX      6'h20
`define MBE_PAGE_BITS     5
`define MBE_PLANE_BIT     12
`define MBE_TOGGLE_BIT    6
`define MBE_CMD_A1        13'h1555
`define MBE_CMD_A2        13'h0aaa
`define MBE_CMD_D1        8'haa
`define MBE_CMD_D2        8'h55
`define MBE_CMD_D3        8'ha0
`define MBE_CMD_D3LOCK    8'h80
`define MBE_CMD_D5LOCK    8'h20
`define MBE_CLK_MHZ       200
`define MBE_PHASE_NS      160
`define MBE_PHASE_CYC     ((`MBE_PHASE_NS * `MBE_CLK_MHZ + 999) / 1000)
`define MBE_LOAD_US       100
`define MBE_LOAD_CYC      (`MBE_LOAD_US * `MBE_CLK_MHZ)
`endif

// ==== mbe_pkg.sv ====
// Types shared by the multiplexed EEPROM host controller.
package mbe_pkg;
   typedef enum logic [5:0]
   {
      ST_IDLE  = 6'h01,
      ST_ADDR  = 6'h02,
      ST_LATCH = 6'h04,
      ST_DATA  = 6'h08,
      ST_END   = 6'h10,
      ST_GAP   = 6'h20
   } mbe_state_t;
endpackage

// ==== mbe_cmd_if.sv ====
// Interface carrying byte cycles from the sequencer to the pin engine.
`timescale 1ns/1ps
interface mbe_cmd_if;
   logic        req;
   logic        isRead;
   logic [12:0] addr;
   logic [7:0]  wdata;
   logic        done;
   logic [7:0]  rdata;
   modport master (output req, output isRead, output addr, output wdata, input done, input rdata);
   modport slave  (input req, input isRead, input addr, input wdata, output done, output rdata);
endinterface

// ==== mbe_pin_engine.sv ====
// Pin engine that runs one multiplexed bus cycle per request.
`timescale 1ns/1ps
`include "mbe_map.svh"
module mbe_pin_engine #(
   parameter int PHASE = `MBE_PHASE_CYC
)(
   // Clock and reset
   input  wire logic        core_clk,
   input  wire logic        resetn,
   // Byte cycle requests
   mbe_cmd_if.slave         cmd,
   // Device pins
   output logic             addressStrobeN,
   output logic             dataStrobeN,
   output logic             readNotWrite,
   output logic [4:0]       upperAddressLines,
   output logic [7:0]       sharedAddrDataOut,
   output logic             sharedAddrDataOe,
   input  wire logic [7:0]  sharedAddrDataIn
);
   mbe_pkg::mbe_state_t stateFf, nxtState;
   logic [7:0] cntFf;
   logic [7:0] syncAFf, syncBFf;
   logic       doneFf;
   logic [7:0] rdataFf;
   wire        phaseEnd = (cntFf == 8'(PHASE - 1));
   assign cmd.done  = doneFf;
   assign cmd.rdata = rdataFf;

   always_comb
   begin
      nxtState = stateFf;
      case (stateFf)
         mbe_pkg::ST_IDLE:  if (cmd.req) nxtState = mbe_pkg::ST_ADDR;
         mbe_pkg::ST_ADDR:  if (phaseEnd) nxtState = mbe_pkg::ST_LATCH;
         mbe_pkg::ST_LATCH: if (phaseEnd) nxtState = mbe_pkg::ST_DATA;
         mbe_pkg::ST_DATA:  if (phaseEnd) nxtState = mbe_pkg::ST_END;
         mbe_pkg::ST_END:   if (phaseEnd) nxtState = mbe_pkg::ST_GAP;
         mbe_pkg::ST_GAP:   nxtState = mbe_pkg::ST_IDLE;
         default:           nxtState = mbe_pkg::ST_IDLE;
      endcase
   end

   always_ff @(posedge core_clk)
   begin
      syncAFf <= sharedAddrDataIn;
      syncBFf <= syncAFf;
      if (!resetn)
      begin
         stateFf <= mbe_pkg::ST_IDLE;
         cntFf <= 8'h00;
         doneFf <= 1'b0;
         rdataFf <= 8'h00;
         addressStrobeN <= 1'b1;
         dataStrobeN <= 1'b1;
         readNotWrite <= 1'b1;
         upperAddressLines <= 5'h00;
         sharedAddrDataOut <= 8'h00;
         sharedAddrDataOe <= 1'b0;
      end
      else
      begin
         stateFf <= nxtState;
         cntFf <= (nxtState != stateFf) ? 8'h00 : cntFf + 8'h01;
         doneFf <= (stateFf == mbe_pkg::ST_GAP);
         // Address goes out on all thirteen lines while the address strobe is low.
         if (stateFf == mbe_pkg::ST_IDLE && cmd.req)
         begin
            addressStrobeN <= 1'b0;
            upperAddressLines <= cmd.addr[12:8];
            sharedAddrDataOut <= cmd.addr[7:0];
            sharedAddrDataOe <= 1'b1;
            readNotWrite <= cmd.isRead;
         end
         if (stateFf == mbe_pkg::ST_ADDR && phaseEnd)
            addressStrobeN <= 1'b1;
         if (stateFf == mbe_pkg::ST_LATCH && phaseEnd)
         begin
            dataStrobeN <= 1'b0;
            sharedAddrDataOut <= cmd.wdata;
            sharedAddrDataOe <= !cmd.isRead;
         end
         // Read data is sampled just before the strobe rises, long after access time.
         if (stateFf == mbe_pkg::ST_DATA && phaseEnd)
         begin
            dataStrobeN <= 1'b1;
            if (cmd.isRead)
               rdataFf <= syncBFf;
         end
         if (stateFf == mbe_pkg::ST_END && phaseEnd)
         begin
            sharedAddrDataOe <= 1'b0;
            readNotWrite <= 1'b1;
         end
      end
   end
endmodule

// ==== mbe_host_top.sv ====
// Host controller for a multiplexed-bus dual-plane EEPROM, with AXI4-Lite registers.
`timescale 1ns/1ps
`include "mbe_map.svh"
module mbe_host_top #(
   parameter int LOAD_CYC = `MBE_LOAD_CYC
)(
   // Clock and reset
   input  wire logic        core_clk,
   input  wire logic        resetn,
   // AXI4-Lite slave
   input  wire logic [3:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [3:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   // Device pins
   output logic             addressStrobeN,
   output logic             dataStrobeN,
   output logic             readNotWrite,
   output logic             chipEnable,
   output logic             writeInhibit,
   output logic [4:0]       upperAddressLines,
   output logic [7:0]       sharedAddrDataOut,
   output logic             sharedAddrDataOe,
   input  wire logic [7:0]  sharedAddrDataIn
);
   mbe_cmd_if cmd ();

   logic [12:0] addrFf;
   logic [7:0]  wdataFf;
   logic        inhibitFf, busyFf, toggledFf, readOpFf, pollFf;
   logic [7:0]  rdataRegFf, lastPollFf;
   logic [2:0]  stepFf, lastStepFf;
   logic [5:0]  pageCntFf;
   logic [31:0] windowFf;
   logic [12:0] pageBaseFf;
   logic        reqFf, lockSeqFf;
   logic        awHeldFf, wHeldFf;
   logic [3:0]  awAddrFf;
   logic [31:0] wDataHeldFf;
   logic        engChipEn;

   // Byte address and data of command step n of the protection sequence.
   function automatic logic [20:0] seqByte(input logic [2:0] n, input logic [12:0] a, input logic [7:0] d);
      case (n)
         3'd0:    seqByte = {`MBE_CMD_A1, `MBE_CMD_D1};
         3'd1:    seqByte = {`MBE_CMD_A2, `MBE_CMD_D2};
         3'd2:    seqByte = {`MBE_CMD_A1, `MBE_CMD_D3LOCK};
         3'd3:    seqByte = {`MBE_CMD_A1, `MBE_CMD_D1};
         3'd4:    seqByte = {`MBE_CMD_A2, `MBE_CMD_D2};
         default: seqByte = {a, d};
      endcase
   endfunction

   // Bus write is taken once both address and data have arrived, in either order.
   wire        awHave  = awHeldFf | s_axi_awvalid;
   wire        wHave   = wHeldFf | s_axi_wvalid;
   wire        wrFire  = awHave && wHave && !s_axi_bvalid;
   wire [3:0]  wrAddr  = awHeldFf ? awAddrFf : s_axi_awaddr;
   wire [31:0] wrData  = wHeldFf ? wDataHeldFf : s_axi_wdata;
   wire        wrCtrl  = wrFire && wrAddr == `MBE_REG_CTRL && s_axi_wstrb[0];
   wire        goNow   = wrCtrl && wrData[`MBE_CTRL_GO] && !busyFf;
   wire        lockSeq = wrData[`MBE_CTRL_LOCKSEQ];
   // Both the unlock and the lock sequence open with the same two command bytes.
   wire [2:0]  firstStep = wrData[`MBE_CTRL_READ] ? 3'd5
                         : (lockSeq || wrData[`MBE_CTRL_UNLOCK]) ? 3'd0 : 3'd5;
   wire [20:0] stepByte = (stepFf == 3'd2 && !lockSeqFf) ? {`MBE_CMD_A1, `MBE_CMD_D3}
                         : (stepFf == 3'd5 && lastStepFf == 3'd5 && lockSeqFf) ? {addrFf, wdataFf}
                         : seqByte(stepFf, addrFf, wdataFf);
   wire        pageHit = (addrFf[12:`MBE_PAGE_BITS] == pageBaseFf[12:`MBE_PAGE_BITS]);
   wire        windowOpen = (windowFf != 32'h0);
   wire        arFire  = s_axi_arvalid && s_axi_arready;
   wire [7:0]  statusByte = {5'h00, (pageCntFf == `MBE_PAGE_MAX), toggledFf, busyFf};
   wire [31:0] rdMux = (s_axi_araddr == `MBE_REG_CTRL)   ? {26'h0, lockSeqFf, inhibitFf, pollFf, 3'h0}
                     : (s_axi_araddr == `MBE_REG_ADDR)   ? {19'h0, addrFf}
                     : (s_axi_araddr == `MBE_REG_WDATA)  ? {24'h0, rdataRegFf}
                     : (s_axi_araddr == `MBE_REG_STATUS) ? {24'h0, statusByte} : 32'h0;
   wire        unmapped = !(s_axi_araddr == `MBE_REG_CTRL || s_axi_araddr == `MBE_REG_ADDR
                         || s_axi_araddr == `MBE_REG_WDATA || s_axi_araddr == `MBE_REG_STATUS);

   assign cmd.req    = reqFf;
   assign cmd.isRead = readOpFf;
   assign cmd.addr   = readOpFf ? addrFf : stepByte[20:8];
   assign cmd.wdata  = stepByte[7:0];
   // Chip enable is raised while a request or operation is pending, across a whole command sequence, so the part idles in standby between operations.
   assign engChipEn  = reqFf | busyFf;

   mbe_pin_engine u_engine (
      .core_clk          (core_clk),
      .resetn            (resetn),
      .cmd               (cmd),
      .addressStrobeN    (addressStrobeN),
      .dataStrobeN       (dataStrobeN),
      .readNotWrite      (readNotWrite),
      .upperAddressLines (upperAddressLines),
      .sharedAddrDataOut (sharedAddrDataOut),
      .sharedAddrDataOe  (sharedAddrDataOe),
      .sharedAddrDataIn  (sharedAddrDataIn)
   );

   // Next handshake state, so that every ready leaves the block from a flop with no lost cycle.
   wire        nxtAwHeld = (s_axi_awvalid && s_axi_awready) ? !wrFire : (awHeldFf && !wrFire);
   wire        nxtWHeld  = (s_axi_wvalid && s_axi_wready) ? !wrFire : (wHeldFf && !wrFire);
   wire        nxtBvalid = wrFire || (s_axi_bvalid && !s_axi_bready);
   wire        nxtRvalid = arFire || (s_axi_rvalid && !s_axi_rready);

   always_ff @(posedge core_clk)
   begin
      if (!resetn)
      begin
         awHeldFf <= 1'b0;
         wHeldFf <= 1'b0;
         awAddrFf <= 4'h0;
         wDataHeldFf <= 32'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0;
         s_axi_rresp <= 2'h0;
         s_axi_bresp <= 2'h0;
         s_axi_awready <= 1'b1;
         s_axi_wready <= 1'b1;
         s_axi_arready <= 1'b1;
      end
      else
      begin
         awHeldFf <= nxtAwHeld;
         wHeldFf <= nxtWHeld;
         s_axi_bvalid <= nxtBvalid;
         s_axi_rvalid <= nxtRvalid;
         s_axi_awready <= !nxtAwHeld && !nxtBvalid;
         s_axi_wready <= !nxtWHeld && !nxtBvalid;
         s_axi_arready <= !nxtRvalid;
         if (s_axi_awvalid && s_axi_awready)
            awAddrFf <= s_axi_awaddr;
         if (s_axi_wvalid && s_axi_wready)
            wDataHeldFf <= s_axi_wdata;
         if (arFire)
         begin
            s_axi_rdata <= rdMux;
            s_axi_rresp <= unmapped ? 2'h2 : 2'h0;
         end
      end
   end

   always_ff @(posedge core_clk)
   begin
      if (!resetn)
      begin
         addrFf <= 13'h0000;
         wdataFf <= 8'h00;
         inhibitFf <= 1'b1;
         busyFf <= 1'b0;
         toggledFf <= 1'b0;
         readOpFf <= 1'b0;
         pollFf <= 1'b0;
         rdataRegFf <= 8'h00;
         lastPollFf <= 8'h00;
         stepFf <= 3'd5;
         lastStepFf <= 3'd5;
         pageCntFf <= 6'h00;
         windowFf <= 32'h0;
         pageBaseFf <= 13'h0000;
         reqFf <= 1'b0;
         lockSeqFf <= 1'b0;
         chipEnable <= 1'b0;
         writeInhibit <= 1'b1;
      end
      else
      begin
         chipEnable <= engChipEn;
         writeInhibit <= inhibitFf;
         if (windowOpen)
            windowFf <= windowFf - 32'h1;
         if (!windowOpen)
            pageCntFf <= 6'h00;
         if (wrFire && wrAddr == `MBE_REG_ADDR)
            addrFf <= wrData[12:0];
         if (wrFire && wrAddr == `MBE_REG_WDATA)
            wdataFf <= wrData[7:0];
         if (wrCtrl)
         begin
            // Raising inhibit during a page load aborts it inside the device.
            inhibitFf <= wrData[`MBE_CTRL_INHIBIT];
            pollFf <= wrData[`MBE_CTRL_POLL];
            if (wrData[`MBE_CTRL_INHIBIT])
               windowFf <= 32'h0;
         end
         // Writes that would break the page or overflow it are refused at the host.
         if (goNow && (wrData[`MBE_CTRL_READ] || (pageCntFf != `MBE_PAGE_MAX
             && (!windowOpen || pageHit))))
         begin
            busyFf <= 1'b1;
            reqFf <= 1'b1;
            readOpFf <= wrData[`MBE_CTRL_READ];
            stepFf <= firstStep;
            lockSeqFf <= lockSeq;
            lastStepFf <= 3'd5;
            if (!wrData[`MBE_CTRL_READ] && !windowOpen)
               pageBaseFf <= addrFf;
         end
         else if (reqFf)
            reqFf <= 1'b0;
         if (cmd.done && busyFf)
         begin
            if (readOpFf)
            begin
               rdataRegFf <= cmd.rdata;
               if (pollFf)
                  lastPollFf <= cmd.rdata;
               // Toggle flag compares bit six with the previous polled read, whatever its address or plane.
               toggledFf <= pollFf && (cmd.rdata[`MBE_TOGGLE_BIT] != lastPollFf[`MBE_TOGGLE_BIT]);
               busyFf <= 1'b0;
            end
            else
            begin
               windowFf <= 32'(LOAD_CYC);
               if (stepFf == 3'd5)
               begin
                  pageCntFf <= pageCntFf + 6'h01;
                  busyFf <= 1'b0;
               end
               else
               begin
                  lastStepFf <= stepFf;
                  // The unlock sequence ends after its third byte and goes straight to the data.
                  stepFf <= (stepFf == 3'd2 && !lockSeqFf) ? 3'd5 : stepFf + 3'd1;
                  reqFf <= 1'b1;
               end
            end
         end
      end
   end
endmodule

// ==== mbe_host_top_asserts.sv ====
// Pin and read-channel checks for the multiplexed EEPROM host controller.
`timescale 1ns/1ps
module mbe_host_top_chk (
   // Clock, reset and read channel
   input wire logic       core_clk,
   input wire logic       resetn,
   input wire logic       s_axi_arvalid,
   input wire logic       s_axi_arready,
   input wire logic       s_axi_rvalid,
   // Device pins
   input wire logic       addressStrobeN,
   input wire logic       dataStrobeN,
   input wire logic       readNotWrite,
   input wire logic       chipEnable,
   input wire logic       writeInhibit,
   input wire logic [4:0] upperAddressLines,
   input wire logic [7:0] sharedAddrDataOut,
   input wire logic       sharedAddrDataOe
);
   default clocking @(posedge core_clk);
   endclocking
   default disable iff (!resetn);
   a_addr_latch: assert property ($rose(addressStrobeN) |->
      sharedAddrDataOe && $stable({upperAddressLines, sharedAddrDataOut})) else $error("address moved at strobe rise");
   a_strobe_order: assert property ($fell(dataStrobeN) |-> addressStrobeN && chipEnable)
      else $error("data strobe fell outside an enabled data phase");
   a_dir_steady: assert property (!dataStrobeN |=> dataStrobeN || $stable(readNotWrite))
      else $error("direction changed during data strobe");
   a_read_float: assert property (!dataStrobeN && readNotWrite |-> !sharedAddrDataOe)
      else $error("host drove the shared lines during a read");
   a_write_hold: assert property ($rose(dataStrobeN) && !readNotWrite |->
      sharedAddrDataOe && $stable(sharedAddrDataOut)) else $error("write data not held through strobe rise");
   a_ce_cover: assert property (!addressStrobeN || !dataStrobeN |-> chipEnable)
      else $error("strobe active with chip enable low");
   a_ds_width: assert property ($fell(dataStrobeN) |-> !dataStrobeN [*8])
      else $error("data strobe pulse too short");
   a_reset_idle: assert property (disable iff (1'b0) !resetn |=> addressStrobeN && dataStrobeN &&
      !chipEnable && writeInhibit && !sharedAddrDataOe) else $error("pins not idle after reset");
   a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read answer late");
   c_write: cover property ($rose(dataStrobeN) && !readNotWrite);
   c_read: cover property ($rose(dataStrobeN) && readNotWrite);
   c_abort: cover property ($rose(writeInhibit));
endmodule
bind mbe_host_top mbe_host_top_chk u_chk (.*);

// ==== mbe_dev_model.sv ====
// Behavioural model of the dual-plane multiplexed-bus memory device.
`timescale 1ns/1ps
module mbe_dev_model #(
   parameter int LOAD_NS = 2000,
   parameter int PROG_NS = 20000
)(
   input  wire logic       addressStrobeN,
   input  wire logic       dataStrobeN,
   input  wire logic       readNotWrite,
   input  wire logic       chipEnable,
   input  wire logic       writeInhibit,
   input  wire logic [4:0] upperAddressLines,
   input  wire logic [7:0] sharedAddrDataOut,
   input  wire logic       sharedAddrDataOe,
   output logic      [7:0] sharedAddrDataIn
);
   logic [7:0]  mem [0:8191];
   logic [12:0] pageA [$];
   logic [7:0]  pageD [$];
   logic [12:0] adr = 13'h0000;
   logic [7:0]  dout = 8'h00;
   logic [7:0]  lastBus = 8'h00;
   logic [2:0]  step = 3'h0;
   // Section locks are never reset, as they survive power-down in the part.
   logic [7:0]  lockMask = 8'h00;
   logic        prog = 1'b0;
   logic        busy = 1'b0;
   logic        plane = 1'b0;
   logic        tog = 1'b0;
   int          seq = 0;
   wire         devOe = chipEnable && readNotWrite && !dataStrobeN;
   wire [7:0]   wd = sharedAddrDataOut;
   // No pull resistor on these lines, so a released bus shows the inverse of its last level.
   assign sharedAddrDataIn = sharedAddrDataOe ? wd : devOe ? dout : ~lastBus;
   always @*
      if (sharedAddrDataOe || devOe)
         lastBus = sharedAddrDataOe ? wd : dout;
   initial foreach (mem[i]) mem[i] = 8'hff;
   always @(posedge addressStrobeN)
      adr = {upperAddressLines, wd};
   always @(negedge dataStrobeN)
      if (chipEnable && readNotWrite)
      begin
         tog = tog ^ (busy && adr[12] == plane);
         dout = (busy && adr[12] == plane) ? {1'b0, tog, 6'h00} : mem[adr];
      end
      else if (chipEnable)
      begin
         seq++;
         fork
            commit(seq);
         join_none
      end
   always @(posedge dataStrobeN)
      if (chipEnable && !readNotWrite && !writeInhibit && !prog)
      begin
         if (step == 3'h3)
         begin
            if (!lockMask[adr[12:10]])
            begin
               if (!busy)
                  plane = adr[12];
               busy = 1'b1;
               pageA.push_back(adr);
               pageD.push_back(wd);
            end
         end
         else if (step == 3'h6)
         begin
            lockMask = wd;
            step = 3'h0;
         end
         else
            step = (step == 3'h0 && adr == 13'h1555 && wd == 8'haa) ? 3'h1 :
                   (step == 3'h1 && adr == 13'h0aaa && wd == 8'h55) ? 3'h2 :
                   (step == 3'h2 && adr == 13'h1555 && wd == 8'ha0) ? 3'h3 :
                   (step == 3'h2 && adr == 13'h1555 && wd == 8'h80) ? 3'h4 :
                   (step == 3'h4 && adr == 13'h1555 && wd == 8'haa) ? 3'h5 :
                   (step == 3'h5 && adr == 13'h0aaa && wd == 8'h55) ? 3'h6 : 3'h0;
      end
   always @(posedge writeInhibit)
      if (!prog)
      begin
         pageA.delete();
         pageD.delete();
         busy = 1'b0;
         step = 3'h0;
         seq++;
      end
   task automatic commit(input int s);
      #(LOAD_NS);
      // Once the load window lapses, any later write needs a fresh command sequence.
      if (s == seq && !prog)
      begin
         step = 3'h0;
         if (pageA.size() > 0)
         begin
            prog = 1'b1;
            foreach (pageA[i]) mem[pageA[i]] = pageD[i];
            pageA.delete();
            pageD.delete();
            #(PROG_NS);
            prog = 1'b0;
            busy = 1'b0;
         end
      end
   endtask
endmodule

// ==== mbe_host_top_tb.sv ====
// Self-checking bench for the multiplexed EEPROM host controller.
`timescale 1ns/1ps
module mbe_host_top_tb;
   logic        core_clk = 1'b0;
   logic        resetn = 1'b0;
   logic [3:0]  s_axi_awaddr = 4'h0;
   logic        s_axi_awvalid = 1'b0;
   logic [31:0] s_axi_wdata = 32'h0;
   logic [3:0]  s_axi_wstrb = 4'hf;
   logic        s_axi_wvalid = 1'b0;
   logic        s_axi_bready = 1'b0;
   logic [3:0]  s_axi_araddr = 4'h0;
   logic        s_axi_arvalid = 1'b0;
   logic        s_axi_rready = 1'b0;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   logic [31:0] s_axi_rdata;
   logic        addressStrobeN, dataStrobeN, readNotWrite, chipEnable, writeInhibit, sharedAddrDataOe;
   logic [4:0]  upperAddressLines;
   logic [7:0]  sharedAddrDataOut, sharedAddrDataIn;
   logic [33:0] expQ [$];
   logic [33:0] mskQ [$];
   logic [33:0] e, m;
   int          failures = 0;
   int          checked = 0;
   int          seed = 12663;
   int          n;
   logic [12:0] base;
   logic [7:0]  pd [4];
   logic [31:0] r0, r1, st;
   mbe_host_top #(.LOAD_CYC(400)) u_dut (.*);
   mbe_dev_model #(.LOAD_NS(2000), .PROG_NS(20000)) u_dev (.*);
   initial forever #2.5 core_clk = ~core_clk;
   task automatic finish_test;
      $display("checked %0d failures %0d", checked, failures);
      if (failures == 0 && checked > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   task automatic tmo;
      failures++;
      $display("mismatch handshake expected answer seen none");
      finish_test;
   endtask
   task automatic axw(input logic [3:0] a, input logic [31:0] d);
      int k;
      logic ta, tw, b;
      @(posedge core_clk);
      s_axi_awaddr <= a;
      s_axi_awvalid <= 1'b1;
      s_axi_wdata <= d;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      k = 0;
      do
      begin
         @(negedge core_clk);
         ta = s_axi_awvalid && s_axi_awready;
         tw = s_axi_wvalid && s_axi_wready;
         b = s_axi_bvalid;
         @(posedge core_clk);
         if (ta) s_axi_awvalid <= 1'b0;
         if (tw) s_axi_wvalid <= 1'b0;
         if (b) s_axi_bready <= 1'b0;
         k++;
      end while (!b && k < 300);
      if (!b) tmo;
   endtask
   task automatic axr(input logic [3:0] a, input logic [31:0] ex, input logic [31:0] mk, output logic [31:0] r);
      int k;
      logic ta, v;
      expQ.push_back({2'b00, ex & mk});
      mskQ.push_back(mk == 32'h0 ? 34'h0 : {2'b11, mk});
      @(posedge core_clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      k = 0;
      do
      begin
         @(negedge core_clk);
         ta = s_axi_arvalid && s_axi_arready;
         v = s_axi_rvalid;
         r = s_axi_rdata;
         @(posedge core_clk);
         if (ta) s_axi_arvalid <= 1'b0;
         if (v) s_axi_rready <= 1'b0;
         k++;
      end while (!v && k < 300);
      if (!v) tmo;
   endtask
   // Each byte operation waits for the busy flag to clear, since GO is ignored while busy.
   task automatic op(input logic [5:0] c, input logic [12:0] a, input logic [7:0] d);
      int k;
      logic [31:0] s;
      axw(4'h4, {19'h0, a});
      axw(4'h8, {24'h0, d});
      axw(4'h0, {26'h0, c});
      for (k = 0; k < 400; k++)
      begin
         axr(4'hc, 32'h0, 32'h0, s);
         if (s[0] === 1'b0) break;
      end
      if (k == 400) tmo;
   endtask
   task automatic rd(input logic [12:0] a, input logic [31:0] ex, input logic [31:0] mk, output logic [31:0] r);
      op(6'h0b, a, 8'h00);
      axr(4'h8, ex, mk, r);
   endtask
   function automatic logic [12:0] off(input int i);
      return 13'(i < 2 ? i : 28 + i);
   endfunction
   always @(posedge core_clk)
      if (s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1 && expQ.size() > 0)
      begin
         e = expQ.pop_front();
         m = mskQ.pop_front();
         if (m != 34'h0)
            checked++;
         if (({s_axi_rresp, s_axi_rdata} & m) !== e)
         begin
            failures++;
            $display("mismatch rdata expected %h seen %h", e, {s_axi_rresp, s_axi_rdata} & m);
         end
      end
   initial
   begin
      repeat (100000) @(posedge core_clk);
      tmo;
   end
   initial
   begin
      repeat (10) @(posedge core_clk);
      resetn <= 1'b1;
      axw(4'h0, 32'h0);
      base = 13'($random(seed)) & 13'h0fe0;
      foreach (pd[i]) pd[i] = 8'($random(seed));
      for (int i = 0; i < 4; i++) op(i == 0 ? 6'h05 : 6'h01, base | off(i), pd[i]);
      rd(base | 13'h1000, 32'hff, 32'hff, r0);
      rd(base, 32'h0, 32'h0, r0);
      rd(base, r0 ^ 32'h40, 32'h40, r1);
      axr(4'hc, 32'h2, 32'h2, st);
      for (n = 0; n < 40 && r0 !== r1; n++)
      begin
         rd(base, 32'h0, 32'h0, r0);
         rd(base, 32'h0, 32'h0, r1);
      end
      if (n == 40) tmo;
      axr(4'hc, 32'h0, 32'h2, st);
      for (int i = 0; i < 4; i++) rd(base | off(i), {24'h0, pd[i]}, 32'hff, r0);
      op(6'h01, base | 13'h1005, 8'h3c);
      op(6'h05, base | 13'h1006, 8'h5a);
      axw(4'h0, 32'h10);
      axr(4'h0, 32'h10, 32'h38, st);
      op(6'h15, base | 13'h1007, 8'h66);
      axw(4'h0, 32'h0);
      op(6'h21, base | 13'h1000, 8'hf0);
      op(6'h05, base | 13'h1009, 8'h77);
      axr(4'h4, {19'h0, base | 13'h1009}, 32'hffffffff, st);
      repeat (600) @(posedge core_clk);
      for (int j = 5; j < 10; j++) rd(base | 13'h1000 | 13'(j), 32'hff, 32'hff, r0);
      finish_test;
   end
endmodule
